//--- design/i2css_core.sv
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Full 10-bit address match enters matched state; data bytes then follow.
// - Transmit ack on ninth falling edge with buffer empty clears release.
// - Transmit stretching happens whether or not stretch enable is set.
// - Release clear holds SCL low until software sets it again.
// - Transmit buffer loaded before ninth falling edge: no stretch.
// - Software may set release at any time, whatever the buffer state.
// - Receive with stretch enable holds SCL after each data byte not read before the ninth falling edge.
// - Receive ninth falling edge with buffer full clears release when stretch enable is set.
// - Receive buffer read before ninth falling edge: no stretch.
// - 10-bit address phase stretches when stretch enable is set.
// - After 10-bit addressing, data bytes stretch the same way.
// - With stretch enable, software may clear release, synced to SCL.
// - Clear drives SCL low only once SCL is sampled low.
// - Held SCL stays low until release set; others may hold longer.
// - Without stretch enable, software clears of release are ignored.
// - Master flag on master event; slave flag on addressed message.

`include "i2css_defs.svh"

module i2css_core (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic master_event,
   input wire i2css_pkg::i2css_pins_type pins_in,
   output logic scl_out,
   output logic scl_oe,
   output logic sda_out,
   output logic sda_oe
);
   import i2css_pkg::*;

   i2css_pins_type pins_s;
   logic scl_d_reg;
   logic sda_d_reg;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic ctrl_wr;
   logic stat_wr;
   logic addr_wr;
   logic txb_wr;
   logic rxb_rd;
   logic stretch_enable_reg;
   logic ten_reg;
   logic rel_reg;
   logic [9:0] addr_reg;
   logic sw_rel_set;
   logic sw_rel_clr;
   logic auto_clr;
   i2css_state_type state_reg;
   i2css_state_type after_reg;
   i2css_state_type dec_after;
   logic dec_ack;
   logic [3:0] bitcnt_reg;
   logic [7:0] shreg_reg;
   logic [7:0] rxb_reg;
   logic [7:0] txb_reg;
   logic ack_reg;
   logic kind_reg;
   logic nack_reg;
   logic pend_reg;
   logic tbf_reg;
   logic rbf_reg;
   logic match_reg;
   logic slvf_reg;
   logic mstf_reg;
   logic ovf_reg;
   logic [7:0] byte_in;
   logic rx_state;
   logic byte_done;
   logic rx_store;
   logic ninth_fall;
   logic tx_reload;
   logic tx_load;
   logic hdr_ok;
   logic [15:0] rd_next;

   // ----------------------------------------
   // Pin sampling and bus conditions
   // ----------------------------------------
   i2css_sync #(.WIDTH(2)) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .din(pins_in),
      .dout(pins_s)
   );

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= pins_s.scl;
         sda_d_reg <= pins_s.sda;
      end
   end

   assign scl_rise = pins_s.scl && !scl_d_reg;
   assign scl_fall = !pins_s.scl && scl_d_reg;
   assign start_det = scl_d_reg && pins_s.scl && sda_d_reg && !pins_s.sda;
   assign stop_det = scl_d_reg && pins_s.scl && !sda_d_reg && pins_s.sda;

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   assign ctrl_wr = reg_wr && (reg_addr == `I2CSS_OFS_CTRL);
   assign stat_wr = reg_wr && (reg_addr == `I2CSS_OFS_STAT);
   assign addr_wr = reg_wr && (reg_addr == `I2CSS_OFS_ADDR);
   assign txb_wr = reg_wr && (reg_addr == `I2CSS_OFS_TXB);
   assign rxb_rd = reg_rd && (reg_addr == `I2CSS_OFS_RXB);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stretch_enable_reg <= `I2CSS_STRETCH_ENABLE_RST;
         ten_reg <= `I2CSS_TEN_RST;
         addr_reg <= `I2CSS_ADDR_RST;
      end else begin
         if (ctrl_wr) begin
            stretch_enable_reg <= reg_wdata[`I2CSS_CTRL_STRETCH_ENABLE];
            ten_reg <= reg_wdata[`I2CSS_CTRL_TEN];
         end
         if (addr_wr) begin
            addr_reg <= reg_wdata[9:0];
         end
      end
   end

   // ----------------------------------------
   // Byte framing
   // ----------------------------------------
   assign byte_in = {shreg_reg[6:0], pins_s.sda};
   assign rx_state = (state_reg == ST_ADDR) || (state_reg == ST_ADDR2) ||
                     (state_reg == ST_RX);
   assign byte_done = scl_rise && rx_state &&
                      (bitcnt_reg == `I2CSS_LAST_BIT);
   assign rx_store = byte_done && (state_reg == ST_RX) && !rbf_reg;
   assign ninth_fall = (state_reg == ST_ACK) && scl_fall;
   assign tx_reload = (ninth_fall && (after_reg == ST_TX)) ||
                      ((state_reg == ST_TX_ACK) && scl_fall && !nack_reg);
   assign tx_load = tbf_reg && (tx_reload || pend_reg);
   assign hdr_ok = (byte_in[7:3] == `I2CSS_TEN_HDR) &&
                   (byte_in[2:1] == addr_reg[9:8]);

   always_comb begin
      dec_ack = 1'b0;
      dec_after = ST_IDLE;
      case (state_reg)
         ST_ADDR: begin
            if (ten_reg) begin
               if (hdr_ok && !byte_in[0]) begin
                  dec_ack = 1'b1;
                  dec_after = ST_ADDR2;
               end else if (hdr_ok && match_reg) begin
                  dec_ack = 1'b1;
                  dec_after = ST_TX;
               end
            end else if (byte_in[7:1] == addr_reg[6:0]) begin
               dec_ack = 1'b1;
               dec_after = byte_in[0] ? ST_TX : ST_RX;
            end
         end
         ST_ADDR2: begin
            if (byte_in == addr_reg[7:0]) begin
               dec_ack = 1'b1;
               dec_after = ST_RX;
            end
         end
         ST_RX: begin
            if (!rbf_reg) begin
               dec_ack = 1'b1;
               dec_after = ST_RX;
            end
         end
         default: begin
            dec_ack = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         after_reg <= ST_IDLE;
         bitcnt_reg <= 4'h0;
         ack_reg <= 1'b0;
         kind_reg <= 1'b0;
         nack_reg <= 1'b0;
      end else if (start_det) begin
         state_reg <= ST_ADDR;
         bitcnt_reg <= 4'h0;
      end else if (stop_det) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_ADDR, ST_ADDR2, ST_RX: begin
               if (scl_rise) begin
                  bitcnt_reg <= bitcnt_reg + 4'h1;
               end
               if (byte_done) begin
                  ack_reg <= dec_ack;
                  after_reg <= dec_after;
                  kind_reg <= (state_reg == ST_RX);
               end
               if (scl_fall && bitcnt_reg == `I2CSS_BITS) begin
                  state_reg <= ST_ACK;
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  state_reg <= after_reg;
                  bitcnt_reg <= 4'h0;
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  bitcnt_reg <= bitcnt_reg + 4'h1;
               end
               if (scl_fall && bitcnt_reg == `I2CSS_BITS) begin
                  state_reg <= ST_TX_ACK;
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) begin
                  nack_reg <= pins_s.sda;
               end
               if (scl_fall) begin
                  state_reg <= nack_reg ? ST_IDLE : ST_TX;
                  bitcnt_reg <= 4'h0;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Shifter and data buffers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         shreg_reg <= 8'h00;
      end else if (tx_load) begin
         shreg_reg <= txb_reg;
      end else if (state_reg == ST_TX && scl_fall &&
                   bitcnt_reg != 4'h0 && bitcnt_reg != `I2CSS_BITS) begin
         shreg_reg <= {shreg_reg[6:0], 1'b0};
      end else if (scl_rise && rx_state) begin
         shreg_reg <= byte_in;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rxb_reg <= 8'h00;
         rbf_reg <= 1'b0;
         ovf_reg <= 1'b0;
      end else begin
         if (rx_store) begin
            rxb_reg <= byte_in;
            rbf_reg <= 1'b1;
         end else if (rxb_rd) begin
            rbf_reg <= 1'b0;
         end
         if (byte_done && state_reg == ST_RX && rbf_reg) begin
            ovf_reg <= 1'b1;
         end else if (stat_wr && reg_wdata[`I2CSS_ST_OVF]) begin
            ovf_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         txb_reg <= 8'h00;
         tbf_reg <= 1'b0;
         pend_reg <= 1'b0;
      end else begin
         if (txb_wr) begin
            txb_reg <= reg_wdata[7:0];
            tbf_reg <= 1'b1;
         end else if (tx_load) begin
            tbf_reg <= 1'b0;
         end
         if (stop_det) begin
            pend_reg <= 1'b0;
         end else if (tx_reload && !tbf_reg) begin
            pend_reg <= 1'b1;
         end else if (tx_load) begin
            pend_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Clock stretching
   // ----------------------------------------
   assign sw_rel_set = ctrl_wr && reg_wdata[`I2CSS_CTRL_REL];
   assign sw_rel_clr = ctrl_wr && !reg_wdata[`I2CSS_CTRL_REL] &&
                       stretch_enable_reg;
   assign auto_clr = (tx_reload && !tbf_reg) ||
                     (ninth_fall && kind_reg && stretch_enable_reg &&
                      rbf_reg) ||
                     (ninth_fall && !kind_reg && ten_reg && stretch_enable_reg &&
                      ack_reg);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rel_reg <= `I2CSS_REL_RST;
      end else if (sw_rel_set) begin
         rel_reg <= 1'b1;
      end else if (auto_clr || sw_rel_clr) begin
         rel_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scl_oe <= 1'b0;
      end else begin
         scl_oe <= !rel_reg && (scl_oe || !pins_s.scl);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sda_oe <= 1'b0;
      end else begin
         sda_oe <= ((state_reg == ST_ACK) && ack_reg) ||
                   ((state_reg == ST_TX) && !pend_reg && !shreg_reg[7]);
      end
   end

   assign scl_out = 1'b0;
   assign sda_out = 1'b0;

   // ----------------------------------------
   // Event flags and address state
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         match_reg <= 1'b0;
         slvf_reg <= 1'b0;
         mstf_reg <= 1'b0;
      end else begin
         if (stop_det) begin
            match_reg <= 1'b0;
         end else if (byte_done && state_reg == ST_ADDR2) begin
            match_reg <= dec_ack;
         end
         if (ninth_fall && ack_reg && !kind_reg &&
             after_reg != ST_ADDR2) begin
            slvf_reg <= 1'b1;
         end else if (stat_wr && reg_wdata[`I2CSS_ST_SLVF]) begin
            slvf_reg <= 1'b0;
         end
         if (master_event) begin
            mstf_reg <= 1'b1;
         end else if (stat_wr && reg_wdata[`I2CSS_ST_MSTF]) begin
            mstf_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always_comb begin
      rd_next = 16'h0000;
      case (reg_addr)
         `I2CSS_OFS_CTRL: begin
            rd_next[`I2CSS_CTRL_STRETCH_ENABLE] = stretch_enable_reg;
            rd_next[`I2CSS_CTRL_REL] = rel_reg;
            rd_next[`I2CSS_CTRL_TEN] = ten_reg;
         end
         `I2CSS_OFS_STAT: begin
            rd_next[`I2CSS_ST_TBF] = tbf_reg;
            rd_next[`I2CSS_ST_RBF] = rbf_reg;
            rd_next[`I2CSS_ST_MATCH] = match_reg;
            rd_next[`I2CSS_ST_XMIT] = (state_reg == ST_TX) ||
                                      (state_reg == ST_TX_ACK);
            rd_next[`I2CSS_ST_SLVF] = slvf_reg;
            rd_next[`I2CSS_ST_MSTF] = mstf_reg;
            rd_next[`I2CSS_ST_OVF] = ovf_reg;
         end
         `I2CSS_OFS_ADDR: rd_next[9:0] = addr_reg;
         `I2CSS_OFS_TXB: rd_next[7:0] = txb_reg;
         `I2CSS_OFS_RXB: rd_next[7:0] = rxb_reg;
         default: rd_next = 16'h0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= reg_rd ? rd_next : 16'h0000;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_hold_low;
      @(posedge clk) disable iff (sys_rst)
      !rel_reg && !pins_s.scl |=> scl_oe;
   endproperty
   a_hold_low: assert property (p_hold_low)
      else $error("scl not held while release clear");

   property p_let_go;
      @(posedge clk) disable iff (sys_rst)
      rel_reg |=> !scl_oe;
   endproperty
   a_let_go: assert property (p_let_go)
      else $error("scl held after release");

   property p_tx_stretch;
      @(posedge clk) disable iff (sys_rst)
      tx_reload && !tbf_reg && !sw_rel_set |=> !rel_reg ##1 scl_oe;
   endproperty
   a_tx_stretch: assert property (p_tx_stretch)
      else $error("transmit did not stretch on empty buffer");

   property p_tx_nostr;
      @(posedge clk) disable iff (sys_rst)
      tx_reload && tbf_reg && rel_reg && !sw_rel_clr |=> rel_reg && !pend_reg;
   endproperty
   a_tx_nostr: assert property (p_tx_nostr)
      else $error("transmit stretched with buffer loaded");

   property p_rx_stretch;
      @(posedge clk) disable iff (sys_rst)
      ninth_fall && kind_reg && stretch_enable_reg && rbf_reg && !sw_rel_set
      |=> !rel_reg;
   endproperty
   a_rx_stretch: assert property (p_rx_stretch)
      else $error("receive did not stretch on full buffer");

   property p_rx_nostr;
      @(posedge clk) disable iff (sys_rst)
      ninth_fall && kind_reg && !rbf_reg && rel_reg && !sw_rel_clr
      |=> rel_reg;
   endproperty
   a_rx_nostr: assert property (p_rx_nostr)
      else $error("receive stretched with buffer empty");

   property p_sw_set;
      @(posedge clk) disable iff (sys_rst)
      sw_rel_set |=> rel_reg;
   endproperty
   a_sw_set: assert property (p_sw_set)
      else $error("software set of release lost");

   property p_sw_clr;
      @(posedge clk) disable iff (sys_rst)
      ctrl_wr && stretch_enable_reg && !reg_wdata[`I2CSS_CTRL_REL] |=> !rel_reg;
   endproperty
   a_sw_clr: assert property (p_sw_clr)
      else $error("software clear of release lost");

   property p_ignore;
      @(posedge clk) disable iff (sys_rst)
      ctrl_wr && !stretch_enable_reg && rel_reg && !auto_clr |=> rel_reg;
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("release cleared while stretch disabled");

   property p_addr_str;
      @(posedge clk) disable iff (sys_rst)
      ninth_fall && !kind_reg && ten_reg && stretch_enable_reg && ack_reg &&
      !sw_rel_set |=> !rel_reg;
   endproperty
   a_addr_str: assert property (p_addr_str)
      else $error("10-bit address phase did not stretch");

   property p_full_match;
      @(posedge clk) disable iff (sys_rst)
      byte_done && state_reg == ST_ADDR2 && byte_in == addr_reg[7:0] &&
      !start_det && !stop_det |=> match_reg && after_reg == ST_RX;
   endproperty
   a_full_match: assert property (p_full_match)
      else $error("full address match not recorded");

   property p_flags;
      @(posedge clk) disable iff (sys_rst)
      master_event |=> mstf_reg;
   endproperty
   a_flags: assert property (p_flags)
      else $error("master event flag not set");

   property p_reset;
      @(posedge clk) disable iff (sys_rst)
      $past(sys_rst) |-> rel_reg && !stretch_enable_reg && !scl_oe;
   endproperty
   a_reset: assert property (p_reset)
      else $error("bad state after reset");

endmodule : i2css_core

`default_nettype wire

//--- design/i2css_defs.svh
`ifndef I2CSS_DEFS_SVH
`define I2CSS_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define I2CSS_OFS_CTRL 8'h00
`define I2CSS_OFS_STAT 8'h04
`define I2CSS_OFS_ADDR 8'h08
`define I2CSS_OFS_TXB 8'h0c
`define I2CSS_OFS_RXB 8'h10

// ----------------------------------------
// Control fields
// ----------------------------------------
`define I2CSS_CTRL_STRETCH_ENABLE 0
`define I2CSS_CTRL_REL 1
`define I2CSS_CTRL_TEN 2

// ----------------------------------------
// Status fields
// ----------------------------------------
`define I2CSS_ST_TBF 0
`define I2CSS_ST_RBF 1
`define I2CSS_ST_MATCH 2
`define I2CSS_ST_XMIT 3
`define I2CSS_ST_SLVF 4
`define I2CSS_ST_MSTF 5
`define I2CSS_ST_OVF 6

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define I2CSS_REL_RST 1'b1
`define I2CSS_STRETCH_ENABLE_RST 1'b0
`define I2CSS_TEN_RST 1'b0
`define I2CSS_ADDR_RST 10'h000
`define I2CSS_TEN_HDR 5'h1e
`define I2CSS_LAST_BIT 4'h7
`define I2CSS_BITS 4'h8

`endif

//--- design/i2css_pkg.sv
package i2css_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ADDR2 = 3'b010,
      ST_RX = 3'b011,
      ST_ACK = 3'b100,
      ST_TX = 3'b101,
      ST_TX_ACK = 3'b110
   } i2css_state_type;

   typedef struct packed {
      logic scl;
      logic sda;
   } i2css_pins_type;

endpackage : i2css_pkg

//--- design/i2css_sync.sv
`timescale 1ns/1ns
`default_nettype none

module i2css_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_reg;

   // ----------------------------------------
   // Two stage synchroniser, idle high
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_reg <= '1;
         dout <= '1;
      end else begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end

endmodule : i2css_sync

`default_nettype wire

//--- test/i2css_core_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "i2css_defs.svh"
// ----------------------------------------
// Bench for the slave stretch core
// ----------------------------------------
module i2css_core_tb;
   import i2css_pkg::*;
   localparam logic [7:0] CTL = `I2CSS_OFS_CTRL;
   localparam logic [7:0] STA = `I2CSS_OFS_STAT;
   localparam logic [7:0] TXB = `I2CSS_OFS_TXB;
   localparam logic [7:0] RXB = `I2CSS_OFS_RXB;
   logic clk, sys_rst, reg_wr, reg_rd, master_event, rd_d, ack;
   logic scl_out, scl_oe, sda_out, sda_oe, m_scl_low, m_sda_low, held;
   logic [7:0] reg_addr, d1, d2, t1, t2, rx;
   logic [15:0] reg_wdata, reg_rdata;
   logic [6:0] a7;
   logic [9:0] a10;
   logic [31:0] e;
   logic [31:0] exp_q[$];
   int mismatches = 0;
   int check_count = 0;
   wire scl_w = !(m_scl_low || scl_oe);
   wire sda_w = !(m_sda_low || sda_oe);
   wire i2css_pins_type pins = {scl_w, sda_w};
   i2css_core i_i2css_core (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .master_event(master_event),
      .pins_in(pins), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_out(sda_out), .sda_oe(sda_oe));
   i2css_master i_i2css_master (.scl(scl_w), .sda(sda_w),
      .scl_low(m_scl_low), .sda_low(m_sda_low), .held(held));
   // ----------------------------------------
   // Checks and bus tasks
   // ----------------------------------------
   task automatic check_val(input string n, input logic [15:0] x,
      input logic [15:0] g);
      check_count++;
      if (g !== x) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, x, g);
      end
   endtask : check_val
   task automatic check_pin(input string n, input logic x, input logic g);
      check_count++;
      if (g !== x) begin
         mismatches++;
         $display("ERROR %s expected %b seen %b", n, x, g);
      end
   endtask : check_pin
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] x,
      input logic [15:0] m);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back({m, x & m});
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd
   task automatic oe_is(input logic x);
      repeat (20) @(posedge clk);
      #1;
      check_pin("scl_oe", x, scl_oe);
   endtask : oe_is
   task automatic wait_held();
      for (int n = 0; n < 4000 && !held; n++) @(posedge clk);
      check_pin("held", 1'b1, held);
   endtask : wait_held
   task automatic send(input logic [7:0] b);
      i_i2css_master.xfer(b, 1'b1, rx, ack);
      check_pin("ack", 1'b0, ack);
   endtask : send
   task automatic fetch(input logic [7:0] x, input logic ack_in);
      i_i2css_master.xfer(8'hff, ack_in, rx, ack);
      check_val("rx byte", {8'h00, x}, {8'h00, rx});
   endtask : fetch
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize
   always @(posedge clk) begin
      rd_d <= reg_rd;
      if (rd_d === 1'b1) begin
         e = exp_q.pop_front();
         check_val("reg_rdata", e[15:0], reg_rdata & e[31:16]);
      end
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = !clk;
   end
   initial begin
      #200000;
      mismatches++;
      summarize();
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {reg_wr, reg_rd, master_event, rd_d} = 4'h0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      sys_rst = 1'b1;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      void'($urandom(32'h72c18945));
      a7 = {3'b010, 4'($urandom())};
      a10 = 10'($urandom());
      d1 = 8'($urandom());
      d2 = 8'($urandom());
      t1 = 8'($urandom());
      t2 = 8'($urandom());
      rd(CTL, 16'h0002, 16'hffff); // Reset control
      rd(STA, 16'h0000, 16'hffff); // Flags clear
      rd(8'h14, 16'h0000, 16'hffff);
      check_val("pin outs", 16'h0000, {14'h0000, scl_out, sda_out});
      wr(CTL, 16'h0000);
      rd(CTL, 16'h0002, 16'hffff); // Clear ignored
      $display("test reset done");
      wr(`I2CSS_OFS_ADDR, {9'h000, a7});
      wr(CTL, 16'h0003);
      i_i2css_master.start();
      send({a7, 1'b0}); // Addressed
      send(d1);
      oe_is(1'b1); // Held after byte
      rd(STA, 16'h0012, 16'h0013); // Buffer and slave flag
      rd(CTL, 16'h0001, 16'h0003); // Release cleared
      rd(RXB, {8'h00, d1}, 16'h00ff); // Emptied while held
      oe_is(1'b1); // Still held
      wr(CTL, 16'h0003);
      oe_is(1'b0); // Freed by set
      fork
         i_i2css_master.xfer(d2, 1'b1, rx, ack);
         begin
            while (i_i2css_master.bit_idx != 8) @(posedge clk);
            rd(RXB, {8'h00, d2}, 16'h00ff); // Early read
         end
      join
      oe_is(1'b0); // No stretch
      i_i2css_master.stop();
      $display("test receive done");
      wr(CTL, 16'h0002);
      i_i2css_master.start();
      send({a7, 1'b1});
      oe_is(1'b1); // Transmit stretch
      rd(CTL, 16'h0000, 16'h0002); // Release cleared
      wr(TXB, {8'h00, t1});
      wr(CTL, 16'h0002); // Set taken
      fork
         fetch(t1, 1'b0);
         begin
            while (i_i2css_master.bit_idx != 2) @(posedge clk);
            wr(TXB, {8'h00, t2});
         end
      join
      oe_is(1'b0); // Loaded in time
      fetch(t2, 1'b1);
      i_i2css_master.stop();
      $display("test transmit done");
      wr(CTL, 16'h0003);
      wr(CTL, 16'h0001);
      oe_is(1'b0); // SCL high, not driven
      rd(CTL, 16'h0001, 16'h0003); // Clear taken
      fork
         begin
            i_i2css_master.start();
            send({a7, 1'b0});
         end
         begin
            wait_held();
            check_pin("scl_oe", 1'b1, scl_oe); // After fall
            wr(CTL, 16'h0003); // Frees SCL
         end
      join
      i_i2css_master.stop();
      $display("test software stretch done");
      @(posedge clk);
      master_event <= 1'b1;
      @(posedge clk);
      master_event <= 1'b0;
      rd(STA, 16'h0020, 16'h0020); // Master flag
      wr(STA, 16'h0030);
      rd(STA, 16'h0000, 16'h0030); // Flags cleared
      $display("test flags done");
      wr(`I2CSS_OFS_ADDR, {6'h00, a10});
      wr(CTL, 16'h0007);
      i_i2css_master.start();
      send({`I2CSS_TEN_HDR, a10[9:8], 1'b0});
      oe_is(1'b1); // Header stretch
      wr(CTL, 16'h0007);
      send(a10[7:0]);
      oe_is(1'b1); // Address stretch
      rd(STA, 16'h0004, 16'h0004); // Full match
      wr(CTL, 16'h0007);
      send(d1); // Data after match
      oe_is(1'b1); // Receive stretch
      rd(RXB, {8'h00, d1}, 16'h00ff); // Data byte
      wr(CTL, 16'h0007);
      i_i2css_master.start();
      send({`I2CSS_TEN_HDR, a10[9:8], 1'b1});
      oe_is(1'b1); // Transmit stretch
      wr(TXB, {8'h00, t1});
      wr(CTL, 16'h0007);
      fetch(t1, 1'b1); // Turned around
      i_i2css_master.stop();
      $display("test ten bit done");
      repeat (3) @(posedge clk);
      summarize();
   end
endmodule : i2css_core_tb
`default_nettype wire

//--- test/i2css_master.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Bus master model, 80 ns clock
// ----------------------------------------
module i2css_master (
   input wire logic scl,
   input wire logic sda,
   output var logic scl_low,
   output var logic sda_low,
   output var logic held
);
   int bit_idx = 9;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      held = 1'b0;
   end
   // Release SCL, wait out any stretch
   task automatic rise();
      scl_low = 1'b0;
      #5;
      held = !scl;
      while (!scl) #10;
      held = 1'b0;
      #35;
   endtask : rise
   task automatic bitio(input logic b, output logic r);
      sda_low = !b;
      #40;
      rise();
      r = sda;
      scl_low = 1'b1;
   endtask : bitio
   // Also serves as repeated start
   task automatic start();
      sda_low = 1'b0;
      #20;
      rise();
      sda_low = 1'b1;
      #20;
      scl_low = 1'b1;
   endtask : start
   task automatic stop();
      sda_low = 1'b1;
      #40;
      rise();
      sda_low = 1'b0;
      #80;
   endtask : stop
   // Eight bits MSB first, then ack bit
   task automatic xfer(input logic [7:0] d, input logic ack_in,
      output logic [7:0] q, output logic ack);
      for (int i = 0; i < 8; i++) begin
         bit_idx = i;
         bitio(d[7-i], q[7-i]);
      end
      bit_idx = 8;
      bitio(ack_in, ack);
      bit_idx = 9;
   endtask : xfer
endmodule : i2css_master
`default_nettype wire
